// ### verilog/input_select_decoder.sv
// Decoder of mode-register span, burnout and channel fields
`timescale 1ns/10ps
module input_select_decoder
	import input_select_pkg::*;
(
	// Clock, reset, enable
	input wire logic core_clk,
	input wire logic reset,
	input wire logic clk_en,
	// Mode register write and read-back
	input wire logic mode_write,
	input wire logic [MODE_WIDTH-1:0] mode_wdata,
	output logic [MODE_WIDTH-1:0] mode_control_reg,
	// Decoded front-end selections
	output logic [SPAN_COUNT-1:0] span_sel_reg,
	output logic unipolar_reg,
	output logic [INPUT_COUNT-1:0] positive_input_reg,
	output logic [INPUT_COUNT-1:0] negative_input_reg,
	output logic input_short_reg,
	output logic [1:0] cal_pair_reg,
	output logic burnout_source_reg,
	output logic burnout_sink_reg
);
	logic [2:0] span_code;
	logic [2:0] channel_code;
	logic burnout_enable;

	// Span one-hot; lowest two codes share the narrowest span
	function automatic logic [SPAN_COUNT-1:0] span_decode(
		input logic [2:0] code);
		logic [SPAN_COUNT-1:0] sel;
		sel = '0;
		if (code <= 3'h1)
			sel[0] = 1'b1;
		else
			sel[code - 3'h1] = 1'b1;
		return sel;
	endfunction

	// Positive input, one-hot over input one..six
	function automatic logic [INPUT_COUNT-1:0] pos_decode(
		input logic [2:0] code);
		case (code)
			3'h0: pos_decode = 6'h01;
			3'h1: pos_decode = 6'h02;
			3'h2: pos_decode = 6'h04;
			3'h3: pos_decode = 6'h08;
			3'h4: pos_decode = 6'h01;
			3'h5: pos_decode = 6'h04;
			3'h6: pos_decode = 6'h10;
			default: pos_decode = 6'h20;
		endcase
	endfunction

	// Negative input; input six is the common return
	function automatic logic [INPUT_COUNT-1:0] neg_decode(
		input logic [2:0] code);
		case (code)
			3'h4: neg_decode = 6'h02;
			3'h5: neg_decode = 6'h08;
			default: neg_decode = 6'h20;
		endcase
	endfunction

	// Only three pairs exist; codes 4 and 5 reuse pairs 0 and 1, codes 2, 3, 6 and 7 fold onto pair 2
	function automatic logic [1:0] pair_decode(input logic [2:0] code);
		case (code)
			3'h0: pair_decode = CAL_PAIR_0;
			3'h1: pair_decode = CAL_PAIR_1;
			3'h4: pair_decode = CAL_PAIR_0;
			3'h5: pair_decode = CAL_PAIR_1;
			default: pair_decode = CAL_PAIR_2;
		endcase
	endfunction

	// Field views of the written word
	assign span_code = mode_wdata[SPAN_MSB:SPAN_LSB];
	assign channel_code = mode_wdata[CHANNEL_MSB:CHANNEL_LSB];
	assign burnout_enable = mode_wdata[BURNOUT_BIT];

	// Mode register store; changes only on a completed write
	always_ff @(posedge core_clk)
	begin
		if (reset)
			mode_control_reg <= MODE_RESET;
		else if (clk_en && mode_write)
			mode_control_reg <= mode_wdata;
	end

	// Span and polarity decode, registered from the write word
	always_ff @(posedge core_clk)
	begin
		if (reset)
		begin
			span_sel_reg <= span_decode(SPAN_RESET);
			unipolar_reg <= 1'b0;
		end
		else if (clk_en && mode_write)
		begin
			span_sel_reg <= span_decode(span_code);
			unipolar_reg <= mode_wdata[POLARITY_BIT];
		end
	end

	// Channel routing and calibration pair
	always_ff @(posedge core_clk)
	begin
		if (reset)
		begin
			positive_input_reg <= pos_decode(CHANNEL_RESET);
			negative_input_reg <= neg_decode(CHANNEL_RESET);
			input_short_reg <= 1'b0;
			cal_pair_reg <= pair_decode(CHANNEL_RESET);
		end
		else if (clk_en && mode_write)
		begin
			positive_input_reg <= pos_decode(channel_code);
			negative_input_reg <= neg_decode(channel_code);
			input_short_reg <= (channel_code == 3'h7);
			cal_pair_reg <= pair_decode(channel_code);
		end
	end

	// Burnout source and sink both follow the burnout bit of the written word
	always_ff @(posedge core_clk)
	begin
		if (reset)
		begin
			burnout_source_reg <= 1'b0;
			burnout_sink_reg <= 1'b0;
		end
		else if (clk_en && mode_write)
		begin
			burnout_source_reg <= burnout_enable;
			burnout_sink_reg <= burnout_enable;
		end
	end
endmodule

// ### verilog/input_select_pkg.sv
// Constants for the mode-register input selection decoder
package input_select_pkg;
	// Mode register geometry
	localparam int MODE_WIDTH = 16;
	localparam int CHANNEL_LSB = 0;
	localparam int CHANNEL_MSB = 2;
	localparam int BURNOUT_BIT = 3;
	localparam int SPAN_LSB = 4;
	localparam int SPAN_MSB = 6;
	localparam int POLARITY_BIT = 12;
	// Reset values
	localparam logic [2:0] SPAN_RESET = 3'h7;
	localparam logic [2:0] CHANNEL_RESET = 3'h4;
	localparam logic [15:0] MODE_RESET = 16'h0074;
	// Span select, one-hot: 20,40,80,160,320,640 mV, 1.28 V
	localparam int SPAN_COUNT = 7;
	// Input select, one-hot bit per analog input one..six
	localparam int INPUT_COUNT = 6;
	// Calibration pair codes
	localparam logic [1:0] CAL_PAIR_0 = 2'h0;
	localparam logic [1:0] CAL_PAIR_1 = 2'h1;
	localparam logic [1:0] CAL_PAIR_2 = 2'h2;
endpackage

// ### tb/mode_host.sv
// Host model that writes the mode register
`timescale 1ns/10ps
module mode_host(
	// Clock and write
	input wire logic core_clk,
	output logic mode_write = 1'b0,
	output logic [15:0] mode_wdata = 16'h0000
);
	// One-cycle write; data inverted once released
	task automatic put(input logic [15:0] w);
		@(negedge core_clk) {mode_write, mode_wdata} = {1'b1, w};
		@(negedge core_clk) {mode_write, mode_wdata} = {1'b0, ~w};
	endtask
endmodule

// ### tb/input_select_checker.sv
// Assertions on the decoder ports
`timescale 1ns/10ps
module input_select_checker(
	// Watched ports
	input wire logic core_clk, reset, clk_en, mode_write,
	input wire logic [15:0] mode_wdata, mode_control_reg,
	input wire logic [6:0] span_sel_reg,
	input wire logic unipolar_reg, input_short_reg,
	input wire logic burnout_source_reg, burnout_sink_reg
);
	default clocking @(posedge core_clk); endclocking
	default disable iff (reset);
	wire tk = clk_en && mode_write;
	sequence taken; tk; endsequence
	chk_word_kept: assert property (
		taken |=> mode_control_reg == $past(mode_wdata)) else $error("word");
	chk_word_held: assert property (
		!tk |=> $stable(mode_control_reg)) else $error("held");
	chk_span_low: assert property (
		taken ##0 !mode_wdata[6:5] |=> span_sel_reg == 7'h01) else $error("lo");
	chk_span_top: assert property (
		taken ##0 &mode_wdata[6:4] |=> span_sel_reg == 7'h40) else $error("hi");
	chk_burn_set: assert property (
		taken |=> burnout_source_reg == $past(mode_wdata[3])) else $error("bo");
	chk_burn_pair: assert property (
		burnout_sink_reg == burnout_source_reg) else $error("sink");
	chk_test_short: assert property (
		input_short_reg == &mode_control_reg[2:0]) else $error("short");
	chk_polarity_copy: assert property (
		unipolar_reg == mode_control_reg[12]) else $error("pol");
endmodule
bind input_select_decoder input_select_checker chk_u(.*);

// ### tb/input_select_decoder_tb.sv
// Self-checking bench for the input select decoder
`timescale 1ns/10ps
module input_select_decoder_tb;
	import input_select_pkg::*;
	logic core_clk = 0, reset = 1, clk_en = 1, mode_write;
	logic unipolar_reg, input_short_reg, burnout_source_reg, burnout_sink_reg;
	logic [15:0] mode_wdata, mode_control_reg, q;
	logic [6:0] span_sel_reg;
	logic [5:0] positive_input_reg, negative_input_reg;
	logic [1:0] cal_pair_reg;
	int bad_count = 0, checks = 0;
	// Channel map nibbles: positive, negative, pair
	localparam logic [31:0] PP = 32'h54203210, NN = 32'h55315555;
	localparam logic [31:0] CP = 32'h22102210;
	wire [40:0] got = {mode_control_reg, span_sel_reg, unipolar_reg,
		positive_input_reg, negative_input_reg, input_short_reg,
		cal_pair_reg, burnout_source_reg, burnout_sink_reg};
	// 10 MHz clock
	always #50 core_clk = ~core_clk;
	mode_host host_u(.*);
	input_select_decoder dut_u(.*);
	// Expected outputs for a stored word
	function automatic logic [40:0] ex(logic [15:0] w);
		int c = w[2:0], s = w[6:4];
		return {w, 7'h01 << (s ? s - 1 : 0), w[12], 6'h01 << PP[4*c+:3],
			6'h01 << NN[4*c+:3], c == 7, CP[4*c+:2], w[3], w[3]};
	endfunction
	task check(logic [40:0] g, e);
		checks++;
		if (g !== e)
		begin
			bad_count++;
			$display("BAD %0t got %h exp %h", $time, g, e);
		end
	endtask
	task tally_and_finish;
		$display("bad_count %0d checks %0d", bad_count, checks);
		if (bad_count == 0 && checks > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	// Sweep every span and channel code, then a write with clk_en low
	initial
	begin
		q = $urandom(32'h11cc);
		repeat (12) @(negedge core_clk);
		reset = 0;
		check(got, ex(MODE_RESET));
		for (int i = 0; i < 64; i++)
		begin
			q = $urandom;
			q[6:0] = {i[5:3], q[3], i[2:0]};
			host_u.put(q);
			check(got, ex(q));
		end
		@(negedge core_clk) clk_en = 0;
		host_u.put(~q);
		check(got, ex(q));
		tally_and_finish;
	end
endmodule
